// ---- verilog/cfg_loader_defines.svh ----
// Purpose: Constants of the configuration stream loader.
// Assumes: A 20 MHz system clock.
// Notes:   Times keep their printed unit; cycle counts derive from them.
`ifndef CFG_LOADER_DEFINES_SVH
`define CFG_LOADER_DEFINES_SVH

// ----------------------------------------
// Widths and address map
// ----------------------------------------
`define DATA_W          8
`define ADDR_W          8
`define BANK_W          2
`define BANK_OFS_W      6
`define BANK_LAST       6'h3F
`define TERMINAL_COUNT  8'hFF
`define MEM_DEPTH       256
`define FIFO_DEPTH      4
`define CNT_W           18

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_KHZ                20000
`define RELEASE_DELAY_MIN_MS   0.5
`define RELEASE_DELAY_MAX_S_MS 3
`define RELEASE_DELAY_MAX_P_MS 30
`define BROWNOUT_MIN_MS        10
`define RELEASE_DELAY_CYC      int'($ceil(`RELEASE_DELAY_MIN_MS * `CLK_KHZ))
`define BROWNOUT_CYC           int'($ceil(`BROWNOUT_MIN_MS * `CLK_KHZ))

// ----------------------------------------
// Bit positions in the synchronised pin vector
// ----------------------------------------
`define PIN_W        12
`define PIN_CE_N     11
`define PIN_OER      10
`define PIN_CFG       9
`define PIN_BUSY      8
`define PIN_CCLK      7
`define PIN_VLOW      6
`define PIN_REV_HI    5
`define PIN_REV_LO    4
`define PIN_PVAR      3
`define PIN_REVEN     2
`define PIN_POUT      1
`define PIN_DECOMP    0

`endif

// ---- verilog/cfg_loader_pkg.sv ----
// Purpose: Types shared by the loader modules.
// Assumes: The defines header is on the include path.
// Notes:   Numbers live in the header; this package holds types only.
package cfg_loader_pkg;
  `include "cfg_loader_defines.svh"

  typedef logic [`DATA_W-1:0] data_t;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`BANK_W-1:0] bank_t;
  typedef logic [`CNT_W-1:0]  cnt_t;
  typedef logic [`PIN_W-1:0]  pins_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_RUN     = 2'h1,
    ST_DONE_TC = 2'h2,
    ST_DONE_EA = 2'h3
  } run_st_t;

  typedef enum logic {
    PW_HOLD = 1'h0,
    PW_UP   = 1'h1
  } pw_st_t;
endpackage

// ---- verilog/stream_if.sv ----
// Purpose: Valid/ready word stream between loader modules.
// Assumes: Source and sink share one clock.
// Notes:   A word moves on an edge where valid and ready are both high.
`timescale 1ns/100ps
interface stream_if #(parameter int W = 8) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- verilog/cfg_mem.sv ----
// Purpose: Bitstream store with a registered read port.
// Assumes: Write and read ports on the same clock.
// Notes:   Contents are not cleared by reset; only the read register is.
`timescale 1ns/100ps
module cfg_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          clock,
  input  wire logic          rstn,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] arr;
    logic [W-1:0]            rd;
  } mem_st_t;

  mem_st_t s_q;
  mem_st_t n;

  // Read data hold while no read is issued, which lets the reader stall.
  always_comb begin
    n = s_q;
    if (we) begin
      n.arr[waddr] = wdata;
    end
    if (re) begin
      n.rd = s_q.arr[raddr];
    end
  end

  // Clearing the whole array would cost a large reset tree for no benefit.
  always_ff @(posedge clock) begin
    s_q <= n;
    if (!rstn) begin
      s_q.rd <= '0;
    end
  end

  assign rdata = s_q.rd;
endmodule

// ---- verilog/cfg_fifo.sv ----
// Purpose: Small word FIFO with valid/ready on both sides and a flush.
// Assumes: DEPTH is a power of two so the pointers wrap by themselves.
// Notes:   Flush drops every stored word in one cycle.
`timescale 1ns/100ps
module cfg_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic flush,
  stream_if.snk     in_s,
  stream_if.src     out_s
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } fifo_st_t;

  fifo_st_t s_q;
  fifo_st_t n;
  logic     push;
  logic     pop;

  // Full and empty come from the word count, never from pointer compare.
  always_comb begin
    n    = s_q;
    push = in_s.valid && (s_q.cnt != FULL);
    pop  = out_s.ready && (s_q.cnt != '0);
    if (flush) begin
      n.wp  = '0;
      n.rp  = '0;
      n.cnt = '0;
    end else begin
      if (push) begin
        n.mem[s_q.wp] = in_s.data;
        n.wp          = s_q.wp + AW'(1);
      end
      if (pop) begin
        n.rp = s_q.rp + AW'(1);
      end
      if (push && !pop) begin
        n.cnt = s_q.cnt + (AW+1)'(1);
      end else if (pop && !push) begin
        n.cnt = s_q.cnt - (AW+1)'(1);
      end
    end
  end

  // Storage is registered with the pointers.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= n;
    end
  end

  assign in_s.ready  = (s_q.cnt != FULL);
  assign out_s.valid = (s_q.cnt != '0);
  assign out_s.data  = s_q.mem[s_q.rp];
endmodule

// ---- verilog/cfg_loader.sv ----
// Purpose: Output control of a configuration memory that streams a
//          stored bitstream to a programmable device.
// Assumes: Pins and the configuration clock are asynchronous to CLOCK and
//          are synchronised here; CCLK runs well below CLOCK / 4.
// Notes:   Straps and revision select are plain pins; no software access.
// Behaviour
// - While chip enable is high the block sits in standby with the address held reset, cascade-out high and all other outputs floating.
// - The address advances with data driven until it equals the terminal count, then it freezes, data float and cascade-out goes low.
// - With revisioning on the parallel variant, the revision's end address stops counting with data and clock out floating; cascade-out is high, low for bank 3.
// - On the parallel variant a high busy input holds the address and the data; the forwarded clock keeps following CCLK.
// - Busy counts only in parallel output mode with decompression off and is ignored otherwise.
// - With revisioning, every address reset loads the start of the selected revision's bank.
// - Without revisioning, every address reset returns the address to zero.
// - After power-on the block holds output-enable/reset low for a release delay within the variant's range.
// - A core supply that stays below the power-down threshold for the set time restarts the power-up hold and its release delay.
// - A low output-enable/reset resets the address, drives cascade-out high and floats the other outputs.
// - During power-up the block actively drives output-enable/reset low until the release delay ends.
`timescale 1ns/100ps
`include "cfg_loader_defines.svh"
module cfg_loader #(
  parameter cfg_loader_pkg::cnt_t RELEASE_DELAY_CYCLES = `CNT_W'(`RELEASE_DELAY_CYC),
  parameter cfg_loader_pkg::cnt_t BROWNOUT_CYCLES      = `CNT_W'(`BROWNOUT_CYC)
) (
  input  wire logic                  CLOCK,
  input  wire logic                  RSTN,
  input  wire logic                  CE_N,
  input  wire logic                  OE_RESET_N_I,
  input  wire logic                  CONFIG_PULSE_N,
  input  wire logic                  BUSY,
  input  wire logic                  CCLK,
  input  wire logic                  VCC_LOW,
  input  wire cfg_loader_pkg::bank_t REV_SEL,
  input  wire logic                  PARALLEL_VARIANT,
  input  wire logic                  REVISION_EN,
  input  wire logic                  PARALLEL_OUT,
  input  wire logic                  DECOMP_EN,
  input  wire logic                  LOAD_WE,
  input  wire cfg_loader_pkg::addr_t LOAD_ADDR,
  input  wire cfg_loader_pkg::data_t LOAD_DATA,
  output cfg_loader_pkg::data_t      DATA,
  output logic                       DATA_OE,
  output logic                       CASCADE_ENABLE_OUT_N,
  output logic                       FORWARDED_CLOCK,
  output logic                       FORWARDED_CLOCK_OE,
  output logic                       OE_RESET_N_O,
  output logic                       OE_RESET_N_OE,
  output logic                       STANDBY
);
  import cfg_loader_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    pins_t   sync_m;
    pins_t   sync_s;
    logic    cclk_d;
    pw_st_t  pw;
    cnt_t    por_cnt;
    cnt_t    bo_cnt;
    run_st_t st;
    bank_t   bank;
    addr_t   addr;
    addr_t   pf_addr;
    logic    rd_pend;
    data_t   data;
    logic    data_oe;
    logic    ceo_n;
    logic    fclk;
    logic    fclk_oe;
    logic    oer_o;
    logic    oer_oe;
    logic    standby;
  } ldr_st_t;

  ldr_st_t s_q;
  ldr_st_t n;

  stream_if #(.W(`DATA_W)) fin ();
  stream_if #(.W(`DATA_W)) fout ();

  data_t   mem_rd;
  logic    mem_re;
  addr_t   mem_raddr;
  logic    flush;
  logic    pop;

  // Decoded views of the second synchroniser stage.
  logic    ce_n_s;
  logic    oer_s;
  logic    cfg_s;
  logic    busy_s;
  logic    cclk_s;
  logic    vlow_s;
  bank_t   rev_s;
  logic    pvar_s;
  logic    rev_on;
  logic    busy_on;
  logic    rst_cond;
  logic    cclk_rise;
  addr_t   start_new;
  addr_t   end_addr;
  addr_t   pf_stop;

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  cfg_mem #(
    .W     (`DATA_W),
    .DEPTH (`MEM_DEPTH),
    .AW    (`ADDR_W)
  ) u_mem (
    .clock (CLOCK),
    .rstn  (RSTN),
    .we    (LOAD_WE),
    .waddr (LOAD_ADDR),
    .wdata (LOAD_DATA),
    .re    (mem_re),
    .raddr (mem_raddr),
    .rdata (mem_rd)
  );

  // The FIFO decouples memory latency from the slow configuration clock.
  cfg_fifo #(
    .W     (`DATA_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clock (CLOCK),
    .rstn  (RSTN),
    .flush (flush),
    .in_s  (fin.snk),
    .out_s (fout.src)
  );

  assign fin.valid  = s_q.rd_pend && !flush;
  assign fin.data   = mem_rd;
  assign fout.ready = pop;

  // Only the second synchroniser stage is ever decoded.
  assign ce_n_s  = s_q.sync_s[`PIN_CE_N];
  assign oer_s   = s_q.sync_s[`PIN_OER];
  assign cfg_s   = s_q.sync_s[`PIN_CFG];
  assign busy_s  = s_q.sync_s[`PIN_BUSY];
  assign cclk_s  = s_q.sync_s[`PIN_CCLK];
  assign vlow_s  = s_q.sync_s[`PIN_VLOW];
  assign rev_s   = s_q.sync_s[`PIN_REV_HI:`PIN_REV_LO];
  assign pvar_s  = s_q.sync_s[`PIN_PVAR];

  // Revisioning exists only on the parallel-capable variant.
  assign rev_on    = pvar_s && s_q.sync_s[`PIN_REVEN];
  assign busy_on   = pvar_s && s_q.sync_s[`PIN_POUT] && !s_q.sync_s[`PIN_DECOMP];
  assign start_new = rev_on ? {rev_s, `BANK_OFS_W'(0)} : `ADDR_W'(0);
  assign end_addr  = {s_q.bank, `BANK_LAST};
  assign pf_stop   = rev_on ? end_addr : `TERMINAL_COUNT;
  assign cclk_rise = cclk_s && !s_q.cclk_d;
  // The pin level already includes our own drive while power-up holds it.
  assign rst_cond  = ce_n_s || !oer_s || (s_q.pw == PW_HOLD);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    n         = s_q;
    mem_re    = 1'b0;
    mem_raddr = s_q.pf_addr;
    flush     = 1'b0;
    pop       = 1'b0;

    n.sync_m = {CE_N, OE_RESET_N_I, CONFIG_PULSE_N, BUSY, CCLK, VCC_LOW,
                REV_SEL, PARALLEL_VARIANT, REVISION_EN, PARALLEL_OUT, DECOMP_EN};
    n.sync_s = s_q.sync_m;
    n.cclk_d = cclk_s;

    // Supply supervision: a long enough low supply restarts the power-up hold.
    if (vlow_s) begin
      n.bo_cnt = s_q.bo_cnt + `CNT_W'(1);
    end else begin
      n.bo_cnt = '0;
    end
    if (vlow_s && (s_q.bo_cnt == BROWNOUT_CYCLES - `CNT_W'(1))) begin
      n.pw      = PW_HOLD;
      n.por_cnt = '0;
      n.bo_cnt  = '0;
    end else if (s_q.pw == PW_HOLD) begin
      if (s_q.por_cnt == RELEASE_DELAY_CYCLES - `CNT_W'(1)) begin
        n.pw = PW_UP;
      end else begin
        n.por_cnt = s_q.por_cnt + `CNT_W'(1);
      end
    end
    // Open-drain style: drive low while holding, otherwise float for the pull-up.
    n.oer_o  = 1'b0;
    n.oer_oe = (n.pw == PW_HOLD);

    n.fclk    = cclk_s;
    n.standby = ce_n_s;

    if (rst_cond) begin
      // Held reset: address parked, cascade high, everything else floating.
      flush     = 1'b1;
      n.st      = ST_IDLE;
      n.bank    = rev_s;
      n.addr    = start_new;
      n.pf_addr = start_new;
      n.rd_pend = 1'b0;
      n.data_oe = 1'b0;
      n.fclk_oe = 1'b0;
      n.ceo_n   = 1'b1;
    end else if (pvar_s && !cfg_s) begin
      // Config pulse low restarts the stream but keeps the outputs driven.
      flush     = 1'b1;
      n.st      = ST_RUN;
      n.bank    = rev_s;
      n.addr    = start_new;
      n.pf_addr = start_new;
      n.rd_pend = 1'b0;
      n.data_oe = 1'b1;
      n.fclk_oe = 1'b1;
      n.ceo_n   = 1'b1;
    end else begin
      case (s_q.st)
        ST_IDLE: begin
          n.st      = ST_RUN;
          n.data_oe = 1'b1;
          n.fclk_oe = pvar_s;
          n.ceo_n   = 1'b1;
        end
        ST_RUN: begin
          // Stops are judged on a clock edge so the last word keeps a full period.
          if (cclk_rise) begin
            if (s_q.addr == `TERMINAL_COUNT) begin
              n.st      = ST_DONE_TC;
              n.data_oe = 1'b0;
              n.fclk_oe = 1'b0;
              n.ceo_n   = 1'b0;
            end else if (rev_on && (s_q.addr == end_addr)) begin
              n.st      = ST_DONE_EA;
              n.data_oe = 1'b0;
              n.fclk_oe = 1'b0;
              n.ceo_n   = 1'b1;
            end else if (busy_on && busy_s) begin
              n.addr = s_q.addr;
            end else if (fout.valid) begin
              pop    = 1'b1;
              n.data = fout.data;
              n.addr = s_q.addr + `ADDR_W'(1);
            end
          end
          // Prefetch runs ahead and stalls when the FIFO refuses a word.
          if (s_q.pf_addr != pf_stop && (!s_q.rd_pend || fin.ready)) begin
            mem_re    = 1'b1;
            n.pf_addr = s_q.pf_addr + `ADDR_W'(1);
            n.rd_pend = 1'b1;
          end else if (s_q.rd_pend && fin.ready) begin
            n.rd_pend = 1'b0;
          end
        end
        ST_DONE_TC: begin
          n.ceo_n = 1'b0;
        end
        ST_DONE_EA: begin
          n.ceo_n = 1'b1;
        end
        default: begin
          n.st = ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Reset starts the power-up hold with the pin driven low at once.
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      s_q        <= '0;
      s_q.ceo_n  <= 1'b1;
      s_q.oer_oe <= 1'b1;
    end else begin
      s_q <= n;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------
  assign DATA                 = s_q.data;
  assign DATA_OE              = s_q.data_oe;
  assign CASCADE_ENABLE_OUT_N = s_q.ceo_n;
  assign FORWARDED_CLOCK      = s_q.fclk;
  assign FORWARDED_CLOCK_OE   = s_q.fclk_oe;
  assign OE_RESET_N_O         = s_q.oer_o;
  assign OE_RESET_N_OE        = s_q.oer_oe;
  assign STANDBY              = s_q.standby;
endmodule

// ---- tb/cfg_loader_properties.sv ----
// Purpose: Timing checks on the pins of the stream loader.
// Assumes: Bound to cfg_loader; one clock domain.
// Notes:   Windows allow for the two-flop input synchronisers.
`timescale 1ns/100ps
module cfg_loader_properties #(
  parameter cfg_loader_pkg::cnt_t RELEASE_DELAY_CYCLES = 18'h0_0014
) (
  input wire logic                  CLOCK,
  input wire logic                  RSTN,
  input wire logic                  CE_N,
  input wire logic                  OE_RESET_N_I,
  input wire logic                  CONFIG_PULSE_N,
  input wire logic                  BUSY,
  input wire logic                  PARALLEL_VARIANT,
  input wire logic                  PARALLEL_OUT,
  input wire logic                  DECOMP_EN,
  input wire cfg_loader_pkg::data_t DATA,
  input wire logic                  DATA_OE,
  input wire logic                  CASCADE_ENABLE_OUT_N,
  input wire logic                  FORWARDED_CLOCK_OE,
  input wire logic                  OE_RESET_N_O,
  input wire logic                  OE_RESET_N_OE,
  input wire logic                  STANDBY
);
  import cfg_loader_pkg::*;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  int   hold_q;
  logic first_q;
  // Cycles the wire has been pulled low since reset.
  always_ff @(posedge CLOCK) begin
    if (!RSTN || !OE_RESET_N_OE) begin
      hold_q <= 0;
    end else begin
      hold_q <= hold_q + 1;
    end
  end
  // Only the power-up release is timed; a brown-out restarts the wait.
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      first_q <= 1'b1;
    end else if (!OE_RESET_N_OE) begin
      first_q <= 1'b0;
    end
  end
  standby_quiet_a: assert property (
    STANDBY |-> !DATA_OE && !FORWARDED_CLOCK_OE && CASCADE_ENABLE_OUT_N)
    else $error("standby with outputs driven");
  chip_off_a: assert property (
    CE_N [*4] |-> STANDBY && !DATA_OE && CASCADE_ENABLE_OUT_N)
    else $error("chip enable high did not stop output");
  wire_low_a: assert property (
    !OE_RESET_N_I [*4] |-> !DATA_OE && !FORWARDED_CLOCK_OE && CASCADE_ENABLE_OUT_N)
    else $error("low reset wire did not stop output");
  reset_hold_a: assert property (
    $rose(RSTN) |-> OE_RESET_N_OE && !OE_RESET_N_O && !DATA_OE)
    else $error("reset wire not held low after reset");
  rel_delay_a: assert property (
    $fell(OE_RESET_N_OE) && first_q |-> hold_q >= int'(RELEASE_DELAY_CYCLES) - 1
      && hold_q <= int'(RELEASE_DELAY_CYCLES) + 2)
    else $error("reset wire released at wrong time");
  busy_hold_a: assert property (
    (BUSY && PARALLEL_VARIANT && PARALLEL_OUT && !DECOMP_EN && DATA_OE) [*5]
      |-> $stable(DATA) && FORWARDED_CLOCK_OE)
    else $error("data moved while busy");
  end_float_a: assert property (
    !CASCADE_ENABLE_OUT_N |-> !DATA_OE && !FORWARDED_CLOCK_OE)
    else $error("outputs driven after terminal count");
  cfg_pulse_a: assert property (
    (PARALLEL_VARIANT && !CONFIG_PULSE_N && !CE_N && OE_RESET_N_I && DATA_OE) [*4]
      |=> DATA_OE && FORWARDED_CLOCK_OE && CASCADE_ENABLE_OUT_N)
    else $error("config pulse floated the outputs");
  cover property ($fell(CASCADE_ENABLE_OUT_N));
  cover property (BUSY && DATA_OE && PARALLEL_OUT && !DECOMP_EN);
  cover property (!CONFIG_PULSE_N && DATA_OE);
endmodule

// ---- tb/fpga_port_model.sv ----
// Purpose: Configuration port of the downstream programmable device.
// Assumes: Tasks are called at the falling edge of the clock.
// Notes:   A word is taken just before each configuration clock fall.
`timescale 1ns/100ps
module fpga_port_model #(
  parameter int HALF = 6
) (
  input  wire logic                  clock,
  input  wire logic                  data_oe,
  input  wire cfg_loader_pkg::data_t data,
  output logic                       cclk,
  output logic                       busy
);
  import cfg_loader_pkg::*;
  data_t got[$];
  // The clock stands low between frames so the loader sees no rising edge and holds its address.
  initial begin
    cclk = 1'b0;
    busy = 1'b0;
  end
  // One clock period per word; a floating bus is never sampled.
  task automatic rises(input int n);
    repeat (n) begin
      cclk = 1'b1;
      repeat (HALF) @(negedge clock);
      if (data_oe === 1'b1) begin
        got.push_back(data);
      end
      cclk = 1'b0;
      repeat (HALF) @(negedge clock);
    end
  endtask
endmodule

// ---- tb/cfg_loader_tb.sv ----
// Purpose: Self-checking bench for the configuration stream loader.
// Assumes: Small release and brown-out counts keep the run short.
// Notes:   Inputs change at the falling clock edge.
`timescale 1ns/100ps
module cfg_loader_tb;
  import cfg_loader_pkg::*;
  logic  clock, rstn, ce_n, cfg_n, vlow, pvar, reven, pout, decomp, we, ext_low;
  logic  dout_oe, ceo_n, fclk, fclk_oe, oer_o, oer_oe, stby, cclk, busy, wire_n;
  bank_t rev, rs;
  addr_t waddr;
  data_t wdata, dout;
  data_t mem[256];
  data_t exp_q[$];
  int    n_mismatch, n_checks, cyc, nb;
  // Pull-up on the shared reset wire; either side may pull it low.
  assign wire_n = ext_low ? 1'b0 : (oer_oe ? oer_o : 1'b1);
  cfg_loader #(.RELEASE_DELAY_CYCLES(18'h0_0014), .BROWNOUT_CYCLES(18'h0_001E)) u_cfg_loader (
    .CLOCK(clock), .RSTN(rstn), .CE_N(ce_n), .OE_RESET_N_I(wire_n),
    .CONFIG_PULSE_N(cfg_n), .BUSY(busy), .CCLK(cclk), .VCC_LOW(vlow), .REV_SEL(rev),
    .PARALLEL_VARIANT(pvar), .REVISION_EN(reven), .PARALLEL_OUT(pout),
    .DECOMP_EN(decomp), .LOAD_WE(we), .LOAD_ADDR(waddr), .LOAD_DATA(wdata),
    .DATA(dout), .DATA_OE(dout_oe), .CASCADE_ENABLE_OUT_N(ceo_n),
    .FORWARDED_CLOCK(fclk), .FORWARDED_CLOCK_OE(fclk_oe), .OE_RESET_N_O(oer_o),
    .OE_RESET_N_OE(oer_oe), .STANDBY(stby));
  fpga_port_model u_fpga_port_model (.clock(clock), .data_oe(dout_oe), .data(dout),
    .cclk(cclk), .busy(busy));
  initial clock = 1'b0;
  always #25 clock = ~clock;
  // A hang ends the run as a failure.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Straps change only in standby, then the stream restarts from its start.
  task automatic start(input logic pv, rv, po, dc, input bank_t r);
    ce_n = 1'b1;
    ticks(6);
    pvar = pv;
    reven = rv;
    pout = po;
    decomp = dc;
    rev = r;
    ticks(6);
    ce_n = 1'b0;
    ticks(20);
    u_fpga_port_model.got.delete();
  endtask
  task automatic expect_run(input int base, input int n);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(mem[base+i]);
    end
  endtask
  task automatic cmp_words();
    check(u_fpga_port_model.got.size(), exp_q.size());
    foreach (exp_q[i]) begin
      check(u_fpga_port_model.got[i], exp_q[i]);
    end
    exp_q.delete();
    u_fpga_port_model.got.delete();
  endtask
  // Word index seen at rise k when busy covers rises 3 to 3+nb-1.
  function automatic int busy_idx(input int k, input int n, input bit hon);
    if (!hon || k < 3) return k;
    if (k < 3 + n) return 2;
    return k - n;
  endfunction
  initial begin
    {rstn, cfg_n, ce_n} = 3'b011;
    {vlow, pvar, reven, pout, decomp, we, ext_low} = 7'h00;
    {rev, waddr, wdata, cyc, n_mismatch, n_checks} = '0;
    void'($urandom(32'h0000_8505));
    ticks(3);
    rstn = 1'b1;
    ticks(10);
    check(oer_oe, 1'b1);
    // Random stray writes first; the full load below overwrites every word.
    repeat (8) begin
      {we, waddr, wdata} = 17'($urandom);
      ticks(1);
    end
    for (int i = 0; i < 256; i++) begin
      mem[i] = data_t'($urandom);
      we = 1'b1;
      waddr = addr_t'(i);
      wdata = mem[i];
      ticks(1);
    end
    we = 1'b0;
    check(oer_oe, 1'b0);
    // Revisioning stays off, so the other straps must not matter here.
    start(1'($urandom), 1'b0, 1'($urandom), 1'($urandom), bank_t'($urandom));
    u_fpga_port_model.rises(256);
    expect_run(0, 255);
    cmp_words();
    check(ceo_n, 1'b0);
    check(dout_oe, 1'b0);
    check(fclk_oe, 1'b0);
    ce_n = 1'b1;
    ticks(6);
    check(stby, 1'b1);
    check(ceo_n, 1'b1);
    // The serial variant has no revisioning whatever its straps say.
    start(1'b0, 1'($urandom), 1'($urandom), 1'($urandom), bank_t'($urandom));
    u_fpga_port_model.rises(3);
    expect_run(0, 3);
    cmp_words();
    $display("terminal count test done");
    for (int r = 0; r < 4; r++) begin
      start(1'b1, 1'b1, 1'($urandom), 1'($urandom), bank_t'(r));
      u_fpga_port_model.rises(64);
      expect_run(r * 64, 63);
      cmp_words();
      // The last bank ends on the terminal count, which pulls cascade-out low.
      check(ceo_n, (r * 64 + 63 == 255) ? 1'b0 : 1'b1);
      check(fclk_oe, 1'b0);
    end
    $display("revision test done");
    for (int m = 0; m < 4; m++) begin
      start(1'b1, 1'b0, m[0], m[1], bank_t'($urandom));
      nb = 1 + $urandom_range(2);
      u_fpga_port_model.rises(3);
      u_fpga_port_model.busy = 1'b1;
      u_fpga_port_model.rises(nb);
      u_fpga_port_model.busy = 1'b0;
      u_fpga_port_model.rises(2);
      for (int k = 0; k < nb + 5; k++) begin
        exp_q.push_back(mem[busy_idx(k, nb, m == 1)]);
      end
      cmp_words();
    end
    $display("busy test done");
    for (int kd = 0; kd < 2; kd++) begin
      rs = bank_t'($urandom);
      start(1'b1, 1'b1, 1'b1, 1'($urandom), rs);
      u_fpga_port_model.rises(5);
      ext_low = (kd == 0);
      cfg_n = (kd == 0);
      ticks(8);
      check(dout_oe, kd[0]);
      check(fclk_oe, kd[0]);
      check(ceo_n, 1'b1);
      ext_low = 1'b0;
      cfg_n = 1'b1;
      ticks(20);
      u_fpga_port_model.got.delete();
      u_fpga_port_model.rises(3);
      expect_run(int'(rs) * 64, 3);
      cmp_words();
    end
    $display("mid-stream reset test done");
    vlow = 1'b1;
    ticks(25);
    vlow = 1'b0;
    ticks(10);
    check(oer_oe, 1'b0);
    vlow = 1'b1;
    ticks(40);
    check(oer_oe, 1'b1);
    vlow = 1'b0;
    ticks(40);
    check(oer_oe, 1'b0);
    $display("brown-out test done");
    wrap_up();
  end
endmodule
bind cfg_loader cfg_loader_properties #(.RELEASE_DELAY_CYCLES(RELEASE_DELAY_CYCLES)) u_props (
  .CLOCK(CLOCK), .RSTN(RSTN), .CE_N(CE_N), .OE_RESET_N_I(OE_RESET_N_I),
  .CONFIG_PULSE_N(CONFIG_PULSE_N), .BUSY(BUSY), .PARALLEL_VARIANT(PARALLEL_VARIANT),
  .PARALLEL_OUT(PARALLEL_OUT), .DECOMP_EN(DECOMP_EN), .DATA(DATA), .DATA_OE(DATA_OE),
  .CASCADE_ENABLE_OUT_N(CASCADE_ENABLE_OUT_N), .FORWARDED_CLOCK_OE(FORWARDED_CLOCK_OE),
  .OE_RESET_N_O(OE_RESET_N_O), .OE_RESET_N_OE(OE_RESET_N_OE), .STANDBY(STANDBY));
